// File: pkg/qos_cfg.svh
`ifndef QOS_CFG_SVH
`define QOS_CFG_SVH

// register byte offsets
`define OFS_CTRL          8'h00
`define OFS_TAG_MAP       8'h04
`define OFS_STATUS        8'h08
`define OFS_DSCP_MAP0     8'h10
`define OFS_DSCP_MAP1     8'h14
`define OFS_DSCP_MAP2     8'h18
`define OFS_DSCP_MAP3     8'h1c

// control field positions
`define CTRL_TRUST_LSB    0
`define CTRL_TRUST_MSB    1
`define CTRL_DEFPRI_LSB   2
`define CTRL_DEFPRI_MSB   4
`define CTRL_STRICT_BIT   8
`define CTRL_WRITE_MASK   32'h0000_011f

// codepoint field inside the service byte
`define SVC_CP_MSB        7
`define SVC_CP_LSB        2

// reset values
`define CTRL_RESET        32'h0000_0000
`define TAG_MAP_RESET     16'hfa41
`define DSCP_MAP0_RESET   32'h0000_5555
`define DSCP_MAP1_RESET   32'h5555_0000
`define DSCP_MAP2_RESET   32'haaaa_aaaa
`define DSCP_MAP3_RESET   32'hffff_ffff

// per-round packet weights of queues 3..0
`define WEIGHT_Q3         4'h8
`define WEIGHT_Q2         4'h4
`define WEIGHT_Q1         4'h2
`define WEIGHT_Q0         4'h1

`endif

// File: pkg/qos_pkg.sv
package qos_pkg;
   typedef logic [1:0] queue_t;
   typedef logic [2:0] tag_pri_t;
   typedef logic [5:0] codepoint_t;
   typedef enum logic [1:0] {
      tag_priority_only_mode  = 2'h0,
      codepoint_only_mode     = 2'h1,
      tag_then_codepoint_mode = 2'h2,
      codepoint_then_tag_mode = 2'h3
   } trust_mode_e;
   typedef enum logic [1:0] {
      sched_weighted = 2'h1,
      sched_strict   = 2'h2
   } sched_mode_e;
endpackage

// File: verilog/qos_queue_classifier.sv
`include "qos_cfg.svh"
module qos_queue_classifier (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // avalon-mm slave
   input  wire logic [7:0]          address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   output logic      [31:0]         readdata,
   output logic                     waitrequest,
   // frame parser side
   input  wire logic                in_valid,
   input  wire logic                in_tag_present,
   input  wire logic                in_priority_tagged,
   input  wire logic [2:0]          in_tag_priority,
   input  wire logic                in_ip_present,
   input  wire logic [7:0]          in_service_byte,
   // classification result
   output logic                     out_valid,
   output qos_pkg::queue_t          out_queue,
   // scheduler side
   input  wire logic [3:0]          queue_nonempty,
   input  wire logic                sched_take,
   output logic                     grant_valid,
   output qos_pkg::queue_t          grant_queue
);

   logic [31:0]             ctrl;
   logic [15:0]             tag_map;
   logic [31:0]             dscp_map [4];
   logic [3:0]              credit [4];
   qos_pkg::trust_mode_e    trust;
   qos_pkg::sched_mode_e    sched_mode;
   qos_pkg::tag_pri_t       default_pri;
   qos_pkg::codepoint_t     codepoint;
   qos_pkg::tag_pri_t       eff_pri;
   qos_pkg::queue_t         tag_q;
   qos_pkg::queue_t         default_q;
   qos_pkg::queue_t         dscp_q;
   qos_pkg::queue_t         next_queue;
   qos_pkg::queue_t         next_grant;
   logic                    tag_usable;
   logic [3:0]              eligible;
   logic                    reload;
   logic                    bus_go;

   function automatic qos_pkg::queue_t highest(input logic [3:0] v);
      qos_pkg::queue_t q;
      q = 2'h0;
      if (v[3]) begin
         q = 2'h3;
      end else if (v[2]) begin
         q = 2'h2;
      end else if (v[1]) begin
         q = 2'h1;
      end
      return q;
   endfunction

   assign trust       = qos_pkg::trust_mode_e'(
                        ctrl[`CTRL_TRUST_MSB:`CTRL_TRUST_LSB]);
   assign sched_mode  = ctrl[`CTRL_STRICT_BIT] ? qos_pkg::sched_strict
                                               : qos_pkg::sched_weighted;
   assign default_pri = ctrl[`CTRL_DEFPRI_MSB:`CTRL_DEFPRI_LSB];

   // bus: one wait cycle, then the request is accepted
   assign bus_go = (read || write) && !waitrequest;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else if (!waitrequest) begin
         waitrequest <= 1'b1;
      end else if (read || write) begin
         waitrequest <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && waitrequest) begin
         if (address == `OFS_CTRL) begin
            readdata <= ctrl;
         end else if (address == `OFS_TAG_MAP) begin
            readdata <= {16'h0000, tag_map};
         end else if (address == `OFS_STATUS) begin
            readdata <= {24'h000000, queue_nonempty, grant_queue, out_queue};
         end else if (address == `OFS_DSCP_MAP0) begin
            readdata <= dscp_map[0];
         end else if (address == `OFS_DSCP_MAP1) begin
            readdata <= dscp_map[1];
         end else if (address == `OFS_DSCP_MAP2) begin
            readdata <= dscp_map[2];
         end else if (address == `OFS_DSCP_MAP3) begin
            readdata <= dscp_map[3];
         end else begin
            readdata <= 32'h0000_0000;
         end
      end
   end

   // only defined control bits are kept
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `CTRL_RESET;
      end else if (bus_go && write && address == `OFS_CTRL) begin
         ctrl <= writedata & `CTRL_WRITE_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tag_map <= `TAG_MAP_RESET;
      end else if (bus_go && write && address == `OFS_TAG_MAP) begin
         tag_map <= writedata[15:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dscp_map[0] <= `DSCP_MAP0_RESET;
         dscp_map[1] <= `DSCP_MAP1_RESET;
         dscp_map[2] <= `DSCP_MAP2_RESET;
         dscp_map[3] <= `DSCP_MAP3_RESET;
      end else if (bus_go && write) begin
         if (address == `OFS_DSCP_MAP0) begin
            dscp_map[0] <= writedata;
         end else if (address == `OFS_DSCP_MAP1) begin
            dscp_map[1] <= writedata;
         end else if (address == `OFS_DSCP_MAP2) begin
            dscp_map[2] <= writedata;
         end else if (address == `OFS_DSCP_MAP3) begin
            dscp_map[3] <= writedata;
         end
      end
   end

   // classification
   assign codepoint  = in_service_byte[`SVC_CP_MSB:`SVC_CP_LSB];
   // priority-tagged frames carry no usable priority of their own
   assign tag_usable = in_tag_present && !in_priority_tagged;
   assign eff_pri    = tag_usable ? in_tag_priority : default_pri;

   always_comb begin
      tag_q     = tag_map[{eff_pri, 1'b0} +: 2];
      default_q = tag_map[{default_pri, 1'b0} +: 2];
      dscp_q    = dscp_map[codepoint[5:4]][{codepoint[3:0], 1'b0} +: 2];
      case (trust)
         qos_pkg::tag_priority_only_mode: begin
            next_queue = tag_q;
         end
         qos_pkg::codepoint_only_mode: begin
            next_queue = in_ip_present ? dscp_q : default_q;
         end
         qos_pkg::tag_then_codepoint_mode: begin
            if (tag_usable) begin
               next_queue = tag_q;
            end else if (in_ip_present) begin
               next_queue = dscp_q;
            end else begin
               next_queue = default_q;
            end
         end
         default: begin
            next_queue = in_ip_present ? dscp_q : tag_q;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_queue <= 2'h0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_queue <= next_queue;
         end
      end
   end

   // scheduling
   always_comb begin
      eligible[0] = queue_nonempty[0] && (credit[0] != 4'h0);
      eligible[1] = queue_nonempty[1] && (credit[1] != 4'h0);
      eligible[2] = queue_nonempty[2] && (credit[2] != 4'h0);
      eligible[3] = queue_nonempty[3] && (credit[3] != 4'h0);
      // a new round starts when no waiting queue has credit left
      reload = (eligible == 4'h0);
      if (sched_mode == qos_pkg::sched_strict) begin
         next_grant = highest(queue_nonempty);
      end else begin
         next_grant = highest(reload ? queue_nonempty : eligible);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         credit[3] <= `WEIGHT_Q3;
         credit[2] <= `WEIGHT_Q2;
         credit[1] <= `WEIGHT_Q1;
         credit[0] <= `WEIGHT_Q0;
      end else if (sched_take && queue_nonempty != 4'h0 &&
                   sched_mode == qos_pkg::sched_weighted) begin
         credit[3] <= (reload ? `WEIGHT_Q3 : credit[3]) -
                      ((next_grant == 2'h3) ? 4'h1 : 4'h0);
         credit[2] <= (reload ? `WEIGHT_Q2 : credit[2]) -
                      ((next_grant == 2'h2) ? 4'h1 : 4'h0);
         credit[1] <= (reload ? `WEIGHT_Q1 : credit[1]) -
                      ((next_grant == 2'h1) ? 4'h1 : 4'h0);
         credit[0] <= (reload ? `WEIGHT_Q0 : credit[0]) -
                      ((next_grant == 2'h0) ? 4'h1 : 4'h0);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         grant_valid <= 1'b0;
         grant_queue <= 2'h0;
      end else begin
         grant_valid <= sched_take && (queue_nonempty != 4'h0);
         if (sched_take && queue_nonempty != 4'h0) begin
            grant_queue <= next_grant;
         end
      end
   end

endmodule

// File: verification/qos_queue_classifier_assertions.sv
module qos_queue_classifier_checker (
   // clock and reset
   input wire logic            clk,
   input wire logic            rst_n,
   // register bus
   input wire logic            read,
   input wire logic            write,
   input wire logic            waitrequest,
   // frames and scheduler
   input wire logic            in_valid,
   input wire logic            out_valid,
   input wire qos_pkg::queue_t out_queue,
   input wire logic [3:0]      queue_nonempty,
   input wire logic            sched_take,
   input wire logic            grant_valid,
   input wire qos_pkg::queue_t grant_queue
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // nonempty as seen by the pick one cycle back
   logic [3:0] ne_q;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) ne_q <= 4'h0;
      else ne_q <= queue_nonempty;
   a_wait_answer:
      assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus request not answered");
   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   a_wait_idle: assert property (!read && !write |=> waitrequest)
      else $error("answer without request");
   a_class_latency: assert property (in_valid |=> out_valid)
      else $error("classification late");
   a_class_pulse: assert property (!in_valid |=> !out_valid)
      else $error("spurious classification");
   a_queue_hold: assert property (!out_valid |-> $stable(out_queue))
      else $error("queue changed without frame");
   a_grant_cause:
      assert property (sched_take && queue_nonempty != 4'h0 |=> grant_valid)
      else $error("pick not granted");
   a_grant_refuse:
      assert property (!sched_take || queue_nonempty == 4'h0 |=> !grant_valid)
      else $error("grant without pick");
   a_grant_nonempty:
      assert property (grant_valid |-> ne_q[grant_queue])
      else $error("empty queue granted");
endmodule
bind qos_queue_classifier qos_queue_classifier_checker u_chk (.clk(clk),
   .rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
   .in_valid(in_valid), .out_valid(out_valid), .out_queue(out_queue),
   .queue_nonempty(queue_nonempty), .sched_take(sched_take),
   .grant_valid(grant_valid), .grant_queue(grant_queue));

// File: verification/qos_fabric_model.sv
module qos_fabric_model (
   // clock and reset
   input wire logic            clk,
   input wire logic            rst_n,
   // bench control
   input wire logic [3:0]      fill,
   input wire logic            start,
   input wire logic [4:0]      picks,
   // scheduler side
   input wire logic            grant_valid,
   input wire qos_pkg::queue_t grant_queue,
   output logic [3:0]          queue_nonempty,
   output logic                sched_take
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt [4];
   logic [4:0] left;
   // picks every other cycle so each grant lands before the next pick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) cnt[i] <= 8'h0;
         left <= 5'h0;
         sched_take <= 1'b0;
      end else begin
         for (int i = 0; i < 4; i++)
            cnt[i] <= cnt[i] + 8'(fill[i])
               - 8'(grant_valid && grant_queue == 2'(i));
         left <= start ? picks : left - 5'(sched_take);
         sched_take <= !sched_take && left != 5'h0;
      end
   end
   always_comb
      for (int i = 0; i < 4; i++) queue_nonempty[i] = cnt[i] != 8'h0;
endmodule

// File: verification/qos_queue_classifier_bench.sv
`include "qos_cfg.svh"
module qos_queue_classifier_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
   logic in_valid = 1'b0, tag_p = 1'b0, ptag = 1'b0, ip_p = 1'b0;
   logic [7:0] address = 8'h00, sbyte = 8'h00;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic [2:0] pri = 3'h0, defpri;
   logic [3:0] fill = 4'h0, queue_nonempty;
   logic [4:0] picks = 5'h0;
   logic start = 1'b0, waitrequest, out_valid, sched_take, grant_valid;
   qos_pkg::queue_t out_queue, grant_queue;
   int mismatches = 0, num_checks = 0, seed = 32'hcf6ab244;
   int gcnt [4];
   logic [15:0] tagw;
   logic [31:0] cpw [4];
   logic [1:0] mode, lastq;
   always #4 clk = ~clk;
   qos_queue_classifier DUT (.clk(clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .in_valid(in_valid),
      .in_tag_present(tag_p), .in_priority_tagged(ptag),
      .in_tag_priority(pri), .in_ip_present(ip_p), .in_service_byte(sbyte),
      .out_valid(out_valid), .out_queue(out_queue),
      .queue_nonempty(queue_nonempty), .sched_take(sched_take),
      .grant_valid(grant_valid), .grant_queue(grant_queue));
   qos_fabric_model fabric (.clk(clk), .rst_n(rst_n), .fill(fill),
      .start(start), .picks(picks), .grant_valid(grant_valid),
      .grant_queue(grant_queue), .queue_nonempty(queue_nonempty),
      .sched_take(sched_take));
   always @(posedge clk) if (grant_valid === 1'b1) gcnt[grant_queue]++;
   function automatic logic [1:0] tdef(int p);
      return 2'((p == 1 || p == 2) ? 0 : (p < 4) ? 1 : (p < 6) ? 2 : 3);
   endfunction
   function automatic logic [1:0] cdef(int c);
      return 2'((c < 8) ? 1 : (c < 24) ? 0 : (c < 32) ? 1 : (c < 48) ? 2 : 3);
   endfunction
   // priority-tagged frames count as untagged
   function automatic logic [1:0] expq();
      logic ok;
      logic [1:0] tq, cq;
      ok = tag_p && !ptag;
      tq = tagw[2*(ok ? pri : defpri) +: 2];
      cq = cpw[sbyte[7:6]][2*sbyte[5:2] +: 2];
      case (mode)
         2'h0: return tq;
         2'h1: return ip_p ? cq : tagw[2*defpri +: 2];
         2'h2: return (ok || !ip_p) ? tq : cq;
         default: return ip_p ? cq : tq;
      endcase
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      write <= w;
      read <= !w;
      address <= a;
      writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n == 20) begin
         mismatches++;
         results();
      end
   endtask
   task automatic frame;
      logic [1:0] e;
      @(posedge clk);
      in_valid <= 1'b1;
      tag_p <= 1'($random(seed));
      ptag <= 1'($random(seed));
      ip_p <= 1'($random(seed));
      pri <= 3'($random(seed));
      sbyte <= 8'($random(seed));
      @(posedge clk);
      in_valid <= 1'b0;
      e = expq();
      lastq = e;
      @(posedge clk);
      chk({31'h0, out_valid}, 32'h1);
      chk({30'h0, out_queue}, {30'h0, e});
   endtask
   task automatic sched(input int n);
      int k;
      gcnt = '{default: 0};
      @(posedge clk);
      start <= 1'b1;
      picks <= 5'(n);
      @(posedge clk);
      start <= 1'b0;
      for (k = 0; k < 100 && gcnt.sum() < n; k++) @(posedge clk);
      if (k == 100) begin
         mismatches++;
         results();
      end
   endtask
   initial begin
      for (int i = 0; i < 8; i++) tagw[2*i +: 2] = tdef(i);
      for (int c = 0; c < 64; c++) cpw[c/16][2*(c%16) +: 2] = cdef(c);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, `OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `OFS_TAG_MAP, 32'h0);
      chk(rd, {16'h0, tagw});
      for (int w = 0; w < 4; w++) begin
         bus(1'b0, 8'(`OFS_DSCP_MAP0 + 4*w), 32'h0);
         chk(rd, cpw[w]);
      end
      bus(1'b1, `OFS_CTRL, 32'hffff_ffff);
      bus(1'b0, `OFS_CTRL, 32'h0);
      chk(rd, 32'h11f);
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      for (int pass = 0; pass < 2; pass++) begin
         for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            defpri = 3'($random(seed));
            bus(1'b1, `OFS_CTRL, {23'h0, 4'h0, defpri, mode});
            repeat (30) frame();
         end
         // second pass runs on rewritten tables
         tagw = 16'($random(seed));
         bus(1'b1, `OFS_TAG_MAP, {16'h0, tagw});
         for (int w = 0; w < 4; w++) begin
            cpw[w] = $random(seed);
            bus(1'b1, 8'(`OFS_DSCP_MAP0 + 4*w), cpw[w]);
         end
      end
      fill <= 4'hf;
      repeat (16) @(posedge clk);
      fill <= 4'h0;
      sched(15);
      for (int q = 0; q < 4; q++) chk(32'(gcnt[q]), 32'(1 << q));
      bus(1'b1, `OFS_CTRL, 32'h100);
      sched(6);
      chk(32'(gcnt[3]), 32'h6);
      sched(4);
      chk(32'(gcnt[3]), 32'h2);
      chk(32'(gcnt[2]), 32'h2);
      // queue 3 drained, last grant from queue 2
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(rd, {24'h0, 4'h7, 2'h2, lastq});
      results();
   end
endmodule
